// ===== src/master_position_scaling.sv
/*
  Master position scaling: quadrature, sinusoidal and serial channels,
  sub-count interpolation and a four-entry conversion_table, APB slave.
  Assumes sine count/phase and serial words come from logic on pclk;
  encoder pins and channel-present straps are asynchronous.
*/
`timescale 1ns/1ns
module master_position_scaling #(
  parameter int SERVO_CYCLES = master_position_scaling_pkg::SERVO_CYCLES
) (
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [7:0]            paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  enc_a,
  input  wire logic                  enc_b,
  input  wire logic [2:0]            chan_present,
  input  wire logic [19:0]           sin_count,
  input  wire logic [11:0]           sin_phase,
  input  wire logic [31:0]           serial_word,
  input  wire logic                  serial_strobe,
  output logic      [3:0][31:0]      master_pos,
  output logic                       master_pos_strobe
);
  localparam int CW = master_position_scaling_pkg::CNT_W;
  localparam int TW = master_position_scaling_pkg::TMR_W;
  localparam int SF = master_position_scaling_pkg::SCALE_FRAC;
  localparam int NE = master_position_scaling_pkg::N_ENTRY;
  // ------------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------------
  logic a_s1_q, a_s2_q, a_s3_q, b_s1_q, b_s2_q, b_s3_q;
  logic [2:0]          pres_s1_q, pres_s2_q, present_q;
  logic                reinit_q;
  logic [2:0]          decode_q;
  logic                timer_sel_q, atan_en_q;
  logic                up, dn, a_rise, moved;
  logic [CW-1:0]       count_q, count_snap_q;
  logic                dir_q, dir_snap_q;
  logic [TW-1:0]       since_q, period_q;
  logic [TW:0]         rem_q, rem_sh;
  logic [TW-1:0]       den_q;
  logic [9:0]          frac_q;
  logic [3:0]          step_q;
  logic [23:0]         servo_cnt_q;
  logic                tick;
  master_position_scaling_pkg::phase_type st_q;
  logic [31:0]         serial_q, serial_snap_q;
  logic [CW-1:0]       sin_cnt_snap_q;
  logic [11:0]         sin_ph_snap_q;
  logic signed [31:0]  quad_pos10, sin_pos12;
  master_position_scaling_pkg::entry_cfg_type cfg_q [NE];
  logic [31:0]         raw [NE];
  logic [31:0]         scaled [NE];
  logic                acc, wr_en;
  logic [31:0]         rd_d;
  logic                err_d;
  // ------------------------------------------------------------------
  // Pin synchronisers and strap capture
  // ------------------------------------------------------------------
  // Two flops before use, a third for edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {a_s1_q, a_s2_q, a_s3_q} <= 3'h0;
      {b_s1_q, b_s2_q, b_s3_q} <= 3'h0;
    end else begin
      {a_s1_q, a_s2_q, a_s3_q} <= {enc_a, a_s1_q, a_s2_q};
      {b_s1_q, b_s2_q, b_s3_q} <= {enc_b, b_s1_q, b_s2_q};
    end
  end
  // Strap sync runs through reset so reinit sees settled straps
  always_ff @(posedge pclk) begin
    pres_s1_q <= chan_present;
    pres_s2_q <= pres_s1_q;
  end
  // ------------------------------------------------------------------
  // Quadrature and pulse-and-direction decode
  // ------------------------------------------------------------------
  // Decode values 0 and 4 give pulse-and-direction on phase A
  always_comb begin
    a_rise = a_s2_q & ~a_s3_q;
    moved  = (a_s2_q ^ a_s3_q) | (b_s2_q ^ b_s3_q);
    if (decode_q[1:0] == 2'h0) begin
      up = a_rise & ~b_s2_q;
      dn = a_rise & b_s2_q;
    end else begin
      up = moved & (a_s2_q ^ b_s3_q);
      dn = moved & ~(a_s2_q ^ b_s3_q);
    end
    if (decode_q[master_position_scaling_pkg::DECODE_REV_BIT]) begin
      {up, dn} = {dn, up};
    end
  end
  // Counter, direction and edge-to-edge timer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q  <= '0;
      dir_q    <= 1'b1;
      since_q  <= '0;
      period_q <= master_position_scaling_pkg::PERIOD_RESET;
    end else if (up || dn) begin
      count_q  <= up ? count_q + 1'b1 : count_q - 1'b1;
      dir_q    <= up;
      period_q <= (since_q == '1) ? since_q : since_q + 1'b1;
      since_q  <= '0;
    end else if (since_q != '1) begin
      since_q <= since_q + 1'b1;
    end
  end
  // ------------------------------------------------------------------
  // Servo cycle sequencing
  // ------------------------------------------------------------------
  assign tick = (servo_cnt_q == 24'(SERVO_CYCLES - 1));
  // Free-running servo period counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      servo_cnt_q <= '0;
    end else begin
      servo_cnt_q <= tick ? '0 : servo_cnt_q + 1'b1;
    end
  end
  // Snapshot at the start of each servo cycle, then divide, then evaluate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q <= master_position_scaling_pkg::ST_IDLE;
      step_q <= '0;
    end else begin
      unique case (st_q)
        master_position_scaling_pkg::ST_IDLE: begin
          if (tick) begin
            st_q   <= master_position_scaling_pkg::ST_DIVIDE;
            step_q <= '0;
          end
        end
        master_position_scaling_pkg::ST_DIVIDE: begin
          step_q <= step_q + 1'b1;
          if (step_q == 4'(master_position_scaling_pkg::DIV_STEPS - 1)) begin
            st_q <= master_position_scaling_pkg::ST_EVAL;
          end
        end
        master_position_scaling_pkg::ST_EVAL: begin
          st_q <= master_position_scaling_pkg::ST_IDLE;
        end
        default: st_q <= master_position_scaling_pkg::ST_IDLE;
      endcase
    end
  end
  // Restoring divider: fraction = elapsed time over last edge period
  assign rem_sh = {rem_q[TW-1:0], 1'b0};
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_q <= '0;
      den_q <= '1;
      frac_q <= '0;
      count_snap_q <= '0;
      dir_snap_q <= 1'b1;
      sin_cnt_snap_q <= '0;
      sin_ph_snap_q <= '0;
      serial_snap_q <= '0;
    end else if (st_q == master_position_scaling_pkg::ST_IDLE && tick) begin
      rem_q <= (since_q < period_q) ? {1'b0, since_q}
                                    : {1'b0, period_q - 1'b1};
      den_q <= period_q;
      frac_q <= '0;
      count_snap_q <= count_q;
      dir_snap_q <= dir_q;
      sin_cnt_snap_q <= sin_count;
      sin_ph_snap_q <= sin_phase;
      serial_snap_q <= serial_q;
    end else if (st_q == master_position_scaling_pkg::ST_DIVIDE) begin
      if (rem_sh >= {1'b0, den_q}) begin
        rem_q  <= rem_sh - {1'b0, den_q};
        frac_q <= {frac_q[8:0], 1'b1};
      end else begin
        rem_q  <= rem_sh;
        frac_q <= {frac_q[8:0], 1'b0};
      end
    end
  end
  // Serial word latched as it arrives, no extension
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_q <= '0;
    end else if (serial_strobe) begin
      serial_q <= serial_word;
    end
  end
  // ------------------------------------------------------------------
  // Interpolated source words
  // ------------------------------------------------------------------
  // Fraction applied in the direction of the last count
  always_comb begin
    quad_pos10 = $signed({{(22 - CW){count_snap_q[CW-1]}}, count_snap_q,
                          10'h000});
    if (dir_snap_q) begin
      quad_pos10 = quad_pos10 + $signed({22'h0, frac_q});
    end else begin
      quad_pos10 = quad_pos10 - $signed({22'h0, frac_q});
    end
    sin_pos12 = $signed({sin_cnt_snap_q, sin_ph_snap_q});
  end
  // ------------------------------------------------------------------
  // Conversion table entries
  // ------------------------------------------------------------------
  // Master value depends only on the sensors; nothing from the slaves
  generate
    for (genvar n = 0; n < NE; n++) begin : g_entry
      logic signed [64:0] prod;
      always_comb begin
        unique case (cfg_q[n].src)
          master_position_scaling_pkg::SRC_QUAD_SW:
            raw[n] = 32'(quad_pos10 >>> 1);
          master_position_scaling_pkg::SRC_QUAD_HW:
            raw[n] = timer_sel_q ? 32'(quad_pos10 >>> 2) & 32'hffffff00
                                 : 32'(quad_pos10 >>> 2);
          master_position_scaling_pkg::SRC_SIN_SW:
            raw[n] = 32'(sin_pos12 >>> 2);
          master_position_scaling_pkg::SRC_SIN_HW:
            raw[n] = atan_en_q ? 32'(sin_pos12)
                               : 32'(sin_pos12) & 32'hfffff000;
          master_position_scaling_pkg::SRC_SERIAL:
            raw[n] = serial_snap_q;
          default: raw[n] = 32'h00000000;
        endcase
      end
      assign prod = $signed(raw[n]) * $signed({1'b0, cfg_q[n].scale});
      assign scaled[n] = prod[SF+31:SF];
    end
  endgenerate
  // Scaled results refreshed once per servo cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < NE; i++) begin
        master_pos[i] <= 32'h00000000;
      end
    end else if (st_q == master_position_scaling_pkg::ST_EVAL) begin
      for (int i = 0; i < NE; i++) begin
        master_pos[i] <= scaled[i];
      end
    end
  end
  // Strobe marks fresh outputs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      master_pos_strobe <= 1'b0;
    end else begin
      master_pos_strobe <= (st_q == master_position_scaling_pkg::ST_EVAL);
    end
  end
  // ------------------------------------------------------------------
  // APB slave
  // ------------------------------------------------------------------
  assign acc   = psel & penable & ~pready;
  assign wr_en = psel & penable & pready & pwrite & ~pslverr;
  // Read mux and address decode
  always_comb begin
    rd_d  = 32'h00000000;
    err_d = 1'b0;
    if (paddr[7:2] == master_position_scaling_pkg::OFF_CTRL[7:2]) begin
      rd_d[master_position_scaling_pkg::CTRL_DECODE_LSB +: 3] = decode_q;
      rd_d[master_position_scaling_pkg::CTRL_TIMER_BIT] = timer_sel_q;
      rd_d[master_position_scaling_pkg::CTRL_ATAN_BIT]  = atan_en_q;
    end else if (paddr[7:2] == master_position_scaling_pkg::OFF_STATUS[7:2]) begin
      rd_d = {26'h0, st_q, present_q};
    end else if (paddr[7:2] == master_position_scaling_pkg::OFF_QUAD[7:2]) begin
      rd_d = {{(32 - CW){count_q[CW-1]}}, count_q};
    end else if (paddr[7:5] == master_position_scaling_pkg::ENTRY_PAGE) begin
      rd_d = paddr[2] ? cfg_q[paddr[4:3]].scale
                      : {29'h0, cfg_q[paddr[4:3]].src};
    end else if (paddr[7:4] == master_position_scaling_pkg::OUT_PAGE) begin
      rd_d = master_pos[paddr[3:2]];
    end else begin
      err_d = 1'b1;
    end
  end
  // One wait state; write lands at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc;
      prdata  <= acc && !pwrite ? rd_d : 32'h00000000;
      pslverr <= acc & (err_d | (pwrite && paddr[7:4] ==
                        master_position_scaling_pkg::OUT_PAGE));
    end
  end
  // Control register and reinit request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      decode_q    <= master_position_scaling_pkg::DECODE_RESET;
      timer_sel_q <= master_position_scaling_pkg::TIMER_SEL_RESET;
      atan_en_q   <= master_position_scaling_pkg::ATAN_RESET;
      reinit_q    <= 1'b1;
    end else if (wr_en && paddr[7:2] ==
                 master_position_scaling_pkg::OFF_CTRL[7:2]) begin
      decode_q    <= pwdata[master_position_scaling_pkg::CTRL_DECODE_LSB +: 3];
      timer_sel_q <= pwdata[master_position_scaling_pkg::CTRL_TIMER_BIT];
      atan_en_q   <= pwdata[master_position_scaling_pkg::CTRL_ATAN_BIT];
      reinit_q    <= pwdata[master_position_scaling_pkg::CTRL_REINIT_BIT];
    end else begin
      reinit_q <= 1'b0;
    end
  end
  // Entries: auto-created on reinit, otherwise written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      present_q <= 3'h0;
      for (int i = 0; i < NE; i++) begin
        cfg_q[i] <= '{master_position_scaling_pkg::SRC_NULL,
                      master_position_scaling_pkg::SCALE_ONE};
      end
    end else if (reinit_q) begin
      present_q <= pres_s2_q;
      cfg_q[0] <= '{master_position_scaling_pkg::SRC_NULL,
                    master_position_scaling_pkg::SCALE_ONE};
      cfg_q[1] <= !pres_s2_q[0] ? '{master_position_scaling_pkg::SRC_NULL,
                                    master_position_scaling_pkg::SCALE_ONE} :
                  timer_sel_q ? '{master_position_scaling_pkg::SRC_QUAD_SW,
                                  master_position_scaling_pkg::SCALE_SW_TIMER} :
                  '{master_position_scaling_pkg::SRC_QUAD_HW,
                    master_position_scaling_pkg::SCALE_HW_TIMER};
      cfg_q[2] <= !pres_s2_q[1] ? '{master_position_scaling_pkg::SRC_NULL,
                                    master_position_scaling_pkg::SCALE_ONE} :
                  atan_en_q ? '{master_position_scaling_pkg::SRC_SIN_HW,
                                master_position_scaling_pkg::SCALE_ATAN} :
                  '{master_position_scaling_pkg::SRC_SIN_SW,
                    master_position_scaling_pkg::SCALE_SW_SIN};
      cfg_q[3] <= '{pres_s2_q[2] ? master_position_scaling_pkg::SRC_SERIAL
                                 : master_position_scaling_pkg::SRC_NULL,
                    master_position_scaling_pkg::SCALE_ONE};
    end else if (wr_en && paddr[7:5] ==
                 master_position_scaling_pkg::ENTRY_PAGE) begin
      if (paddr[2]) begin
        cfg_q[paddr[4:3]].scale <= pwdata;
      end else begin
        cfg_q[paddr[4:3]].src <= master_position_scaling_pkg::src_type'(pwdata[2:0]);
      end
    end
  end
  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  sequence s_divide_then_eval;
    (st_q == master_position_scaling_pkg::ST_DIVIDE)[*8] ##3
    (st_q == master_position_scaling_pkg::ST_EVAL) ##1 master_pos_strobe;
  endsequence
  property p_servo_eval;
    @(posedge pclk) disable iff (!presetn)
    (st_q == master_position_scaling_pkg::ST_IDLE && tick) |=> s_divide_then_eval;
  endproperty
  a_servo_eval: assert property (p_servo_eval)
    else $error("Entries not evaluated on schedule");
  property p_product;
    @(posedge pclk) disable iff (!presetn)
    (st_q == master_position_scaling_pkg::ST_EVAL) |=>
      master_pos[1] == 32'((65'($signed($past(raw[1]))) *
        $signed({33'h0, $past(cfg_q[1].scale)})) >>> SF);
  endproperty
  a_product: assert property (p_product)
    else $error("Scaled output is not the product");
  property p_serial;
    @(posedge pclk) disable iff (!presetn)
    serial_strobe |=> serial_q == $past(serial_word);
  endproperty
  a_serial: assert property (p_serial)
    else $error("Serial word not latched unchanged");
  property p_reinit_quad;
    @(posedge pclk) disable iff (!presetn)
    (reinit_q && pres_s2_q[0] && !timer_sel_q) |=>
      cfg_q[1].src == master_position_scaling_pkg::SRC_QUAD_HW &&
      cfg_q[1].scale == master_position_scaling_pkg::SCALE_HW_TIMER;
  endproperty
  a_reinit_quad: assert property (p_reinit_quad)
    else $error("Quadrature entry not auto-created");
  property p_pulse_count;
    @(posedge pclk) disable iff (!presetn)
    (decode_q == 3'h0 && a_rise && !b_s2_q) |=> count_q == $past(count_q) + 1'b1;
  endproperty
  a_pulse_count: assert property (p_pulse_count)
    else $error("Pulse-and-direction count wrong");
  property p_sw_timer_frac;
    @(posedge pclk) disable iff (!presetn)
    (cfg_q[1].src == master_position_scaling_pkg::SRC_QUAD_SW && dir_snap_q)
      |-> raw[1][8:0] == frac_q[9:1];
  endproperty
  a_sw_timer_frac: assert property (p_sw_timer_frac)
    else $error("Software timer fraction wrong");
  property p_atan_off;
    @(posedge pclk) disable iff (!presetn)
    (cfg_q[2].src == master_position_scaling_pkg::SRC_SIN_HW && !atan_en_q)
      |-> raw[2][11:0] == 12'h000;
  endproperty
  a_atan_off: assert property (p_atan_off)
    else $error("Arctangent fraction present while disabled");
  property p_apb_answer;
    @(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not one cycle long");
endmodule // master_position_scaling

// ===== include/master_position_scaling_pkg.sv
/*
  Constants, types and register map of the master position scaling block.
  Assumes a 125 MHz APB clock and same-clock sinusoidal and serial sources.
*/
// Functional notes
// - Master signal passes channel hardware, then a conversion_table entry.
// - Reinit creates one entry per detected channel, best type for each.
// - Scale gives sensor counts, or milliseconds at real_time_input_freq.
// - Software timer extension gives 9 fraction bits, scale 1/512.
// - Software sine extension gives 10 fraction bits, scale 1/1024.
// - Hardware timer interpolation runs while timer_interp_select is 0.
// - Hardware timer gives 8 fraction bits, register read scaled 1/256.
// - Hardware arctangent interpolation runs when its enable is 1.
// - Arctangent gives 12 fraction bits, scale 1/4096.
// - Serial position is latched unchanged, scale 1.0.
// - Slave motion never feeds back into the master position.
// - All entries are evaluated at the start of every servo cycle; here inputs are snapshot at the tick and entries evaluated 11 cycles later.
package master_position_scaling_pkg;
  // ------------------------------------------------------------------
  // Widths and timing
  // ------------------------------------------------------------------
  localparam int CNT_W           = 20;
  localparam int TMR_W           = 16;
  localparam int PHASE_W         = 12;
  localparam int SCALE_FRAC      = 24;
  localparam int N_ENTRY         = 4;
  localparam int DIV_STEPS       = 10;
  localparam int CLK_PERIOD_NS   = 8;
  localparam int SERVO_PERIOD_NS = 500000;
  localparam int SERVO_CYCLES    = SERVO_PERIOD_NS / CLK_PERIOD_NS;
  // ------------------------------------------------------------------
  // Register map
  // ------------------------------------------------------------------
  localparam logic [7:0] OFF_CTRL   = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_QUAD   = 8'h08;
  localparam logic [2:0] ENTRY_PAGE = 3'h1;
  localparam logic [3:0] OUT_PAGE   = 4'h4;
  localparam int CTRL_REINIT_BIT    = 0;
  localparam int CTRL_DECODE_LSB    = 8;
  localparam int CTRL_TIMER_BIT     = 12;
  localparam int CTRL_ATAN_BIT      = 13;
  localparam int DECODE_REV_BIT     = 2;
  localparam logic [2:0] DECODE_RESET    = 3'h3;
  localparam logic       TIMER_SEL_RESET = 1'b0;
  localparam logic       ATAN_RESET      = 1'b0;
  localparam logic [TMR_W-1:0] PERIOD_RESET = 16'hffff;
  // Default scales, unsigned with SCALE_FRAC fraction bits
  localparam logic [31:0] SCALE_ONE      = 32'h01000000;
  localparam logic [31:0] SCALE_SW_TIMER = 32'h00008000;
  localparam logic [31:0] SCALE_SW_SIN   = 32'h00004000;
  localparam logic [31:0] SCALE_HW_TIMER = 32'h00010000;
  localparam logic [31:0] SCALE_ATAN     = 32'h00001000;
  // ------------------------------------------------------------------
  // Types
  // ------------------------------------------------------------------
  typedef enum logic [2:0] {
    SRC_NULL    = 3'h0,
    SRC_QUAD_SW = 3'h1,
    SRC_QUAD_HW = 3'h2,
    SRC_SIN_SW  = 3'h3,
    SRC_SIN_HW  = 3'h4,
    SRC_SERIAL  = 3'h5
  } src_type;
  typedef struct packed {
    src_type     src;
    logic [31:0] scale;
  } entry_cfg_type;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_DIVIDE = 3'b010,
    ST_EVAL   = 3'b100
  } phase_type;
endpackage

// ===== tb/encoder_source.sv
/*
  Behavioural model of the master signal sources: pulse train on phase A,
  sine count and phase, and serial position words.
  Assumes the bench calls its tasks from a process on pclk.
*/
`timescale 1ns/1ns
module encoder_source (
  input  wire logic        pclk,
  output logic             enc_a,
  output logic             enc_b,
  output logic [19:0]      sin_count,
  output logic [11:0]      sin_phase,
  output logic [31:0]      serial_word,
  output logic             serial_strobe
);
  // --------------------------------------------------------------
  // Idle levels at time zero
  // --------------------------------------------------------------
  initial begin
    enc_a = 1'b0;
    enc_b = 1'b0;
    sin_count = '0;
    sin_phase = '0;
    serial_word = 32'hffffffff;
    serial_strobe = 1'b0;
  end
  // External clock as pulses on phase A, direction held low for up
  task automatic pulses(input int n);
    for (int i = 0; i < n; i++) begin
      repeat (4) @(posedge pclk);
      enc_a <= 1'b1;
      repeat (4) @(posedge pclk);
      enc_a <= 1'b0;
    end
  endtask
  // Sine count and phase are levels
  task automatic set_sin(input logic [19:0] c, input logic [11:0] p);
    @(posedge pclk);
    sin_count <= c;
    sin_phase <= p;
  endtask
  // Serial word valid only with its strobe, inverted after
  task automatic send_serial(input logic [31:0] w);
    @(posedge pclk);
    serial_word <= w;
    serial_strobe <= 1'b1;
    @(posedge pclk);
    serial_strobe <= 1'b0;
    serial_word <= ~w;
  endtask
endmodule // encoder_source

// ===== tb/master_position_scaling_test.sv
/*
  Self-checking bench of the master position scaling block.
  Assumes the package is compiled first and the source model beside it.
*/
`timescale 1ns/1ns
module master_position_scaling_test;
  logic             pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic             enc_a, enc_b, serial_strobe, master_pos_strobe, er;
  logic [7:0]       paddr;
  logic [2:0]       chan_present;
  logic [31:0]      pwdata, prdata, serial_word, rd;
  logic [19:0]      sin_count;
  logic [11:0]      sin_phase;
  logic [3:0][31:0] master_pos;
  int               n_mismatch, checked, cyc;
  master_position_scaling #(.SERVO_CYCLES(40)) dut (.*);
  encoder_source src (.*);
  // Clock and cycle limit
  initial begin
    pclk = 1'b0;
    forever #4 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("comparisons %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rd);
  endtask
  // Wait for n refreshes of the scaled outputs
  task automatic servo(input int n);
    repeat (n) begin
      @(posedge pclk);
      while (master_pos_strobe !== 1'b1) @(posedge pclk);
    end
  endtask
  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  task automatic t_refuse();
    apb(1'b1, 8'h40, 32'h1);
    chk("output page write error", 1'b1, er);
    apb(1'b0, 8'hfc, 32'h0);
    chk("unmapped error", 1'b1, er);
    chk("unmapped data", 32'h0, rd);
    $display("t_refuse done");
  endtask
  task automatic t_pulse();
    rchk(8'h00, 32'h00000300);
    rchk(8'h28, 32'(master_position_scaling_pkg::SRC_QUAD_HW));
    rchk(8'h2c, master_position_scaling_pkg::SCALE_HW_TIMER);
    rchk(8'h30, 32'(master_position_scaling_pkg::SRC_SIN_SW));
    rchk(8'h38, 32'(master_position_scaling_pkg::SRC_SERIAL));
    src.set_sin(20'h5, 12'h800);
    apb(1'b1, 8'h00, 32'h0);
    src.pulses(8);
    servo(2);
    rchk(8'h08, 32'h8);
    rchk(8'h04, 32'h0000000f);
    chk("hw timer pos", 32'h8, master_pos[1]);
    chk("sw sine pos", 32'h5, master_pos[2]);
    $display("t_pulse done");
  endtask
  task automatic t_interp();
    apb(1'b1, 8'h00, 32'h00003001);
    servo(2);
    rchk(8'h28, 32'(master_position_scaling_pkg::SRC_QUAD_SW));
    rchk(8'h2c, master_position_scaling_pkg::SCALE_SW_TIMER);
    rchk(8'h30, 32'(master_position_scaling_pkg::SRC_SIN_HW));
    rchk(8'h34, master_position_scaling_pkg::SCALE_ATAN);
    chk("sw timer pos", 32'h8, master_pos[1]);
    chk("atan pos", 32'h5, master_pos[2]);
    apb(1'b1, 8'h00, 32'h00001000);
    servo(2);
    chk("atan off pos", 32'h5, master_pos[2]);
    $display("t_interp done");
  endtask
  task automatic t_serial();
    src.send_serial(32'h00001234);
    apb(1'b1, 8'h3c, 32'h00800000);
    servo(2);
    chk("serial half scale", 32'h0000091a, master_pos[3]);
    chk("null entry", 32'h0, master_pos[0]);
    $display("t_serial done");
  endtask
  // Reset, then the scenarios in turn
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    chan_present = 3'b111;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_refuse();
    t_pulse();
    t_interp();
    t_serial();
    complete_run();
  end
endmodule // master_position_scaling_test
